// File: sim/disk_status_alarm_display_test.sv
// Self-checking bench of the status block.
// Assumes the host model drives the register port.
`timescale 1ns/100ps
`default_nettype none
module disk_status_alarm_display_test;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, display_code, d;
	logic [7:0] head_skew = 8'h00;
	logic reg_wr, reg_rd;
	logic ot = 1'b0, vo = 1'b0, hs = 1'b0, rw = 1'b0, nc = 1'b0;
	logic sf = 1'b0, wf = 1'b0, sp = 1'b0, dd = 1'b0, ev = 1'b0;
	dsa_pkg::dsa_event_type ec = dsa_pkg::DSA_EV_IDLE;
	int fail_count = 0;
	int compares = 0;
	always #25 ref_clk = ~ref_clk;
	dsa_host_model host (.clk(ref_clk), .addr(reg_addr), .wdata(reg_wdata),
		.wr(reg_wr), .rd(reg_rd), .rdata(reg_rdata));
	dsa_top uut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .overtemp_pin(ot),
		.voltage_pin(vo), .headsel_pin(hs), .rw_fault_pin(rw),
		.not_oncyl_pin(nc), .seek_fault_pin(sf), .write_fault_pin(wf),
		.spindle_8head_pin(sp), .diag_done(dd), .event_valid(ev),
		.event_code(ec), .head_skew(head_skew), .display_code(display_code));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
		host.rd_byte(a, d);
		chk(d, exp);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic pulse(input dsa_pkg::dsa_event_type e);
		@(posedge ref_clk);
		ev <= 1'b1;
		ec <= e;
		@(posedge ref_clk);
		ev <= 1'b0;
		wait_n(3);
	endtask
	task automatic close_out;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk(display_code, 8'h00);
		pulse(dsa_pkg::DSA_EV_SPINUP);
		chk(display_code, 8'h00);
		$display("reset test done");
	endtask
	task automatic t_status;
		logic [7:0] ex [3] = '{8'h02, 8'h04, 8'h20};
		for (int i = 0; i < 3; i++) begin
			@(posedge ref_clk);
			{hs, vo, ot} <= 3'b001 << i;
			wait_n(8);
			rchk(4'h4, ex[i]);
		end
		@(posedge ref_clk);
		{hs, vo, ot} <= 3'b111;
		sp <= 1'b1;
		head_skew <= 8'hA5;
		wait_n(8);
		rchk(4'h4, 8'h26);
		rchk(4'h6, 8'h01);
		rchk(4'h7, 8'hA5);
		rchk(4'h5, 8'h00);
		rchk(4'hF, 8'h00);
		host.wr_byte(4'h4, 8'hFF);
		rchk(4'h4, 8'h26);
		@(posedge ref_clk);
		{hs, vo, ot} <= 3'b000;
		sp <= 1'b0;
		head_skew <= 8'h5A;
		wait_n(8);
		rchk(4'h4, 8'h00);
		rchk(4'h6, 8'h00);
		rchk(4'h7, 8'h5A);
		host.wr_byte(4'h8, 8'h3C);
		rchk(4'h8, 8'h3C);
		$display("status byte test done");
	endtask
	task automatic t_events;
		logic [7:0] ex [14] = '{8'h01, 8'h01, 8'h02, 8'h03, 8'h03, 8'h04,
			8'h05, 8'h06, 8'h07, 8'h09, 8'h0C, 8'h0D, 8'h0E, 8'h0F};
		@(posedge ref_clk);
		dd <= 1'b1;
		wait_n(3);
		chk(display_code, 8'h01);
		for (int i = 0; i < 14; i++) begin
			pulse(dsa_pkg::dsa_event_type'(i));
			chk(display_code, ex[i]);
			rchk(4'h9, ex[i]);
		end
		pulse(dsa_pkg::DSA_EV_NOT_READY);
		chk(display_code, 8'h01);
		pulse(dsa_pkg::DSA_EV_ONCYL_MISS);
		chk(display_code, 8'h0F);
		$display("display state test done");
	endtask
	task automatic t_faults;
		logic [3:0] v;
		for (int i = 1; i < 16; i++) begin
			v = 4'(i);
			@(posedge ref_clk);
			{wf, sf, nc, rw} <= v;
			wait_n(8);
			chk(display_code, {4'h1, v});
		end
		@(posedge ref_clk);
		{wf, sf, nc, rw} <= 4'h0;
		wait_n(8);
		chk(display_code, 8'h0F);
		@(posedge ref_clk);
		clk_en <= 1'b0;
		pulse(dsa_pkg::DSA_EV_BADSW);
		clk_en <= 1'b1;
		wait_n(3);
		chk(display_code, 8'h0F);
		dd <= 1'b0;
		reset_n <= 1'b0;
		wait_n(3);
		chk(display_code, 8'h00);
		reset_n <= 1'b1;
		wait_n(5);
		chk(display_code, 8'h00);
		dd <= 1'b1;
		wait_n(3);
		chk(display_code, 8'h01);
		$display("fault code test done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		wait_n(20000);
		fail_count++;
		close_out();
	end
	initial begin
		wait_n(20);
		reset_n <= 1'b1;
		wait_n(5);
		t_reset();
		t_status();
		t_events();
		t_faults();
		close_out();
	end
endmodule
`default_nettype wire

// File: sim/dsa_host_model.sv
// Host adapter model: reads and writes status bytes over the register port.
// Assumes one-cycle strobes and read data only in the cycle after the read.
`timescale 1ns/100ps
`default_nettype none
module dsa_host_model (
	input wire logic clk,
	output logic [3:0] addr,
	output logic [7:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [7:0] rdata
);
	initial begin
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic wr_byte(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~d;
	endtask
	task automatic rd_byte(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
endmodule
`default_nettype wire

// File: src/dsa_pkg.sv
// Types shared by the status block.
// Assumes no other package.
package dsa_pkg;
	typedef enum logic [4:0] {
		DSA_EV_IDLE, DSA_EV_NOT_READY, DSA_EV_BADSW, DSA_EV_FIRST_RDY,
		DSA_EV_RDY_LOST, DSA_EV_SERVO_START, DSA_EV_SERVO_END,
		DSA_EV_IO_TMO, DSA_EV_SPINUP, DSA_EV_DIAG_OK, DSA_EV_DIAG_FAIL,
		DSA_EV_CYL_TMO, DSA_EV_ONCYL_STUCK, DSA_EV_ONCYL_MISS
	} dsa_event_type;
endpackage

// File: src/dsa_regs.svh
// Register offsets, field positions and display codes of the status block.
// Assumes inclusion by name from the design files.
`ifndef DSA_REGS_SVH
`define DSA_REGS_SVH
`define DSA_ADDR_W 4
`define DSA_OFF_ALARM_REG 4'h4
`define DSA_OFF_VENDOR1 4'h5
`define DSA_OFF_SPINDLE 4'h6
`define DSA_OFF_SKEW 4'h7
`define DSA_OFF_EVENT 4'h8
`define DSA_OFF_DISPLAY 4'h9
`define DSA_BIT_OVERTEMP 1
`define DSA_BIT_VOLTAGE 2
`define DSA_BIT_HEADSEL 5
`define DSA_BIT_SPINDLE 0
`define DSA_ZERO8 8'h00
`define DSA_ALARM_UNUSED 8'hD9
`define DSA_CODE_INIT 8'h00
`define DSA_CODE_IDLE 8'h01
`define DSA_CODE_BADSW 8'h02
`define DSA_CODE_FIRST_RDY 8'h03
`define DSA_CODE_SERVO_START 8'h04
`define DSA_CODE_SERVO_END 8'h05
`define DSA_CODE_IO_TMO 8'h06
`define DSA_CODE_SPINUP 8'h07
`define DSA_CODE_DIAG_OK 8'h09
`define DSA_CODE_DIAG_FAIL 8'h0C
`define DSA_CODE_CYL_TMO 8'h0D
`define DSA_CODE_ONCYL_STUCK 8'h0E
`define DSA_CODE_ONCYL_MISS 8'h0F
`define DSA_CODE_FAULT_BASE 8'h10
`endif

// File: src/dsa_sync.sv
// Three-stage synchroniser for a bus of pin inputs.
// Assumes one clock; the output changes once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module dsa_sync #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			dout <= '0;
		end else if (ce) begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					dout[i] <= s3_q[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: src/dsa_top.sv
// Status byte assembly and front display code for the drive.
// Assumes fault pins are asynchronous, events come from same-clock logic.
//
// Overview of operation
// - Alarm bit 1 flags logic overtemperature.
// - Alarm bit 2 flags voltage out of range.
// - Alarm bit 5 flags illegal head selection.
// - Byte 6 bit 0 gives spindle head mode.
// - Head skew byte holds low 8 bits of skew value.
// - Display always shows current state or fault.
// - Code 00 after reset until diagnostics pass.
// - Code 01 after diagnostics or not-ready.
// - Code 02 for invalid ID switch setting.
// - Code 03 awaiting first ready or ready loss.
// - Codes 04 and 05 for servo test timeouts.
// - Code 06 when I/O board gets no answer.
// - Code 07 awaiting ready after spin-up.
// - Code 09 when read/write diagnostics pass.
// - Code 0C when read/write diagnostics fail.
// - Code 0D for on-cylinder arrival timeout.
// - Codes 0E and 0F for on-cylinder errors.
// - Codes 11 to 13 for access faults.
// - Codes 14 to 17 with first seek fault.
// - Write fault adds codes 18 through 1F.
`timescale 1ns/100ps
`default_nettype none
`include "dsa_regs.svh"
module dsa_top #(
	parameter int SKEW_W = 8
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [`DSA_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic overtemp_pin,
	input wire logic voltage_pin,
	input wire logic headsel_pin,
	input wire logic rw_fault_pin,
	input wire logic not_oncyl_pin,
	input wire logic seek_fault_pin,
	input wire logic write_fault_pin,
	input wire logic spindle_8head_pin,
	input wire logic diag_done,
	input wire logic event_valid,
	input wire dsa_pkg::dsa_event_type event_code,
	input wire logic [SKEW_W-1:0] head_skew,
	output logic [7:0] display_code
);

	////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisation.
	logic rst_a_q;
	logic rst_n_q;
	logic [7:0] pins_s;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_a_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_a_q <= 1'b1;
			rst_n_q <= rst_a_q;
		end
	end

	dsa_sync #(.W(8)) u_sync (
		.clk(ref_clk),
		.rst_n(rst_n_q),
		.ce(clk_en),
		.din({spindle_8head_pin, write_fault_pin, seek_fault_pin,
			not_oncyl_pin, rw_fault_pin, headsel_pin, voltage_pin,
			overtemp_pin}),
		.dout(pins_s)
	);

	logic overtemp_s, voltage_s, headsel_s, rw_fault_s;
	logic not_oncyl_s, seek_fault_s, write_fault_s, spindle_s;
	assign {spindle_s, write_fault_s, seek_fault_s, not_oncyl_s,
		rw_fault_s, headsel_s, voltage_s, overtemp_s} = pins_s;

	////////////////////////////////////////////////////////////////////////
	// Status bytes.
	logic [7:0] alarm_d;
	logic [7:0] spindle_d;
	logic [7:0] skew_d;

	always_comb begin
		alarm_d = `DSA_ZERO8;
		alarm_d[`DSA_BIT_OVERTEMP] = overtemp_s;
		alarm_d[`DSA_BIT_VOLTAGE] = voltage_s;
		alarm_d[`DSA_BIT_HEADSEL] = headsel_s;
		spindle_d = `DSA_ZERO8;
		spindle_d[`DSA_BIT_SPINDLE] = spindle_s;
		skew_d = 8'(head_skew);
	end

	////////////////////////////////////////////////////////////////////////
	// Display state: power-up code until diagnostics, then fault codes while any fault is set, else event codes.
	logic diag_ok_q;
	logic [7:0] state_code_q;
	logic [7:0] fault_code;
	logic fault_any;
	logic [7:0] display_d;

	function automatic logic [7:0] ev_to_code(dsa_pkg::dsa_event_type ev);
		logic [7:0] c;
		c = `DSA_CODE_IDLE;
		unique case (ev)
			dsa_pkg::DSA_EV_IDLE: c = `DSA_CODE_IDLE;
			dsa_pkg::DSA_EV_NOT_READY: c = `DSA_CODE_IDLE;
			dsa_pkg::DSA_EV_BADSW: c = `DSA_CODE_BADSW;
			dsa_pkg::DSA_EV_FIRST_RDY: c = `DSA_CODE_FIRST_RDY;
			dsa_pkg::DSA_EV_RDY_LOST: c = `DSA_CODE_FIRST_RDY;
			dsa_pkg::DSA_EV_SERVO_START: c = `DSA_CODE_SERVO_START;
			dsa_pkg::DSA_EV_SERVO_END: c = `DSA_CODE_SERVO_END;
			dsa_pkg::DSA_EV_IO_TMO: c = `DSA_CODE_IO_TMO;
			dsa_pkg::DSA_EV_SPINUP: c = `DSA_CODE_SPINUP;
			dsa_pkg::DSA_EV_DIAG_OK: c = `DSA_CODE_DIAG_OK;
			dsa_pkg::DSA_EV_DIAG_FAIL: c = `DSA_CODE_DIAG_FAIL;
			dsa_pkg::DSA_EV_CYL_TMO: c = `DSA_CODE_CYL_TMO;
			dsa_pkg::DSA_EV_ONCYL_STUCK: c = `DSA_CODE_ONCYL_STUCK;
			dsa_pkg::DSA_EV_ONCYL_MISS: c = `DSA_CODE_ONCYL_MISS;
			default: c = `DSA_CODE_IDLE;
		endcase
		return c;
	endfunction

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			diag_ok_q <= 1'b0;
		end else if (clk_en && diag_done) begin
			diag_ok_q <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_code_q <= `DSA_CODE_IDLE;
		end else if (clk_en && event_valid && diag_ok_q) begin
			state_code_q <= ev_to_code(event_code);
		end
	end

	// Fault flags form the low nibble and write fault bit 3 above base 10.
	always_comb begin
		fault_code = `DSA_CODE_FAULT_BASE |
			{4'h0, write_fault_s, seek_fault_s, not_oncyl_s,
			rw_fault_s};
		fault_any = rw_fault_s | not_oncyl_s | seek_fault_s |
			write_fault_s;
	end

	always_comb begin
		if (!diag_ok_q) begin
			display_d = `DSA_CODE_INIT;
		end else if (fault_any) begin
			display_d = fault_code;
		end else begin
			display_d = state_code_q;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			display_code <= `DSA_CODE_INIT;
		end else if (clk_en) begin
			display_code <= display_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register port: read data one cycle after the read strobe.
	logic [7:0] event_reg_q;

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			event_reg_q <= `DSA_ZERO8;
		end else if (clk_en && reg_wr && reg_addr == `DSA_OFF_EVENT) begin
			event_reg_q <= reg_wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			reg_rdata <= `DSA_ZERO8;
		end else if (clk_en) begin
			if (reg_rd) begin
				unique case (reg_addr)
					`DSA_OFF_ALARM_REG: reg_rdata <= alarm_d;
					`DSA_OFF_SPINDLE: reg_rdata <= spindle_d;
					`DSA_OFF_SKEW: reg_rdata <= skew_d;
					`DSA_OFF_EVENT: reg_rdata <= event_reg_q;
					`DSA_OFF_DISPLAY: reg_rdata <= display_code;
					default: reg_rdata <= `DSA_ZERO8;
				endcase
			end else begin
				reg_rdata <= `DSA_ZERO8;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.
	property p_overtemp;
		@(posedge ref_clk) disable iff (!rst_n_q)
		clk_en && reg_rd && reg_addr == `DSA_OFF_ALARM_REG ##1 clk_en
		|-> reg_rdata[`DSA_BIT_OVERTEMP] == $past(overtemp_s);
	endproperty
	a_overtemp: assert property (p_overtemp)
		else $error("overtemp bit wrong");

	property p_voltage;
		@(posedge ref_clk) disable iff (!rst_n_q)
		clk_en && reg_rd && reg_addr == `DSA_OFF_ALARM_REG ##1 clk_en
		|-> reg_rdata[`DSA_BIT_VOLTAGE] == $past(voltage_s);
	endproperty
	a_voltage: assert property (p_voltage)
		else $error("voltage bit wrong");

	property p_headsel;
		@(posedge ref_clk) disable iff (!rst_n_q)
		clk_en && reg_rd && reg_addr == `DSA_OFF_ALARM_REG ##1 clk_en
		|-> reg_rdata[`DSA_BIT_HEADSEL] == $past(headsel_s);
	endproperty
	a_headsel: assert property (p_headsel)
		else $error("head select bit wrong");

	property p_spindle;
		@(posedge ref_clk) disable iff (!rst_n_q)
		clk_en && reg_rd && reg_addr == `DSA_OFF_SPINDLE ##1 clk_en
		|-> reg_rdata == {7'h0, $past(spindle_s)};
	endproperty
	a_spindle: assert property (p_spindle)
		else $error("spindle byte wrong");

	property p_skew;
		@(posedge ref_clk) disable iff (!rst_n_q)
		clk_en && reg_rd && reg_addr == `DSA_OFF_SKEW ##1 clk_en
		|-> reg_rdata == $past(skew_d);
	endproperty
	a_skew: assert property (p_skew)
		else $error("skew byte wrong");

	property p_init;
		@(posedge ref_clk) disable iff (!rst_n_q)
		!diag_ok_q ##1 clk_en |-> display_code == `DSA_CODE_INIT;
	endproperty
	a_init: assert property (p_init)
		else $error("display left 00 early");

	property p_fault;
		@(posedge ref_clk) disable iff (!rst_n_q)
		clk_en && diag_ok_q && seek_fault_s && rw_fault_s && !not_oncyl_s
		&& !write_fault_s ##1 clk_en |-> display_code == 8'h15;
	endproperty
	a_fault: assert property (p_fault)
		else $error("code 15 not shown");

	property p_wfault;
		@(posedge ref_clk) disable iff (!rst_n_q)
		clk_en && diag_ok_q && write_fault_s ##1 clk_en
		|-> display_code[4:3] == 2'b11;
	endproperty
	a_wfault: assert property (p_wfault)
		else $error("write fault code wrong");

	property p_noreserved;
		@(posedge ref_clk) disable iff (!rst_n_q)
		display_code != 8'h08 && display_code != 8'h10 &&
		display_code != 8'h0A && display_code != 8'h0B;
	endproperty
	a_noreserved: assert property (p_noreserved)
		else $error("reserved code shown");

	property p_code_range;
		@(posedge ref_clk) disable iff (!rst_n_q)
		display_code[7:5] == 3'b000;
	endproperty
	a_code_range: assert property (p_code_range)
		else $error("display code out of range");

	property p_vendor;
		@(posedge ref_clk) disable iff (!rst_n_q)
		clk_en && reg_rd && reg_addr == `DSA_OFF_VENDOR1
		|=> reg_rdata == `DSA_ZERO8;
	endproperty
	a_vendor: assert property (p_vendor)
		else $error("vendor byte not zero");

	property p_alarm_unused;
		@(posedge ref_clk) disable iff (!rst_n_q)
		clk_en && reg_rd && reg_addr == `DSA_OFF_ALARM_REG
		|=> (reg_rdata & `DSA_ALARM_UNUSED) == `DSA_ZERO8;
	endproperty
	a_alarm_unused: assert property (p_alarm_unused)
		else $error("alarm unused bits set");

	property p_rdata_idle;
		@(posedge ref_clk) disable iff (!rst_n_q)
		clk_en && !reg_rd |=> reg_rdata == `DSA_ZERO8;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero when idle");

	property p_freeze;
		@(posedge ref_clk) disable iff (!rst_n_q)
		!clk_en |=> $stable(display_code) && $stable(reg_rdata);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while clock enable low");

	property p_not_ready;
		@(posedge ref_clk) disable iff (!rst_n_q)
		clk_en && diag_ok_q && event_valid
		&& event_code == dsa_pkg::DSA_EV_NOT_READY ##1 clk_en && !fault_any
		|=> display_code == `DSA_CODE_IDLE;
	endproperty
	a_not_ready: assert property (p_not_ready)
		else $error("not ready code wrong");

	property p_spinup;
		@(posedge ref_clk) disable iff (!rst_n_q)
		clk_en && diag_ok_q && event_valid
		&& event_code == dsa_pkg::DSA_EV_SPINUP ##1 clk_en && !fault_any
		|=> display_code == `DSA_CODE_SPINUP;
	endproperty
	a_spinup: assert property (p_spinup)
		else $error("spin-up code wrong");

	property p_rwfault;
		@(posedge ref_clk) disable iff (!rst_n_q)
		clk_en && diag_ok_q && rw_fault_s && !not_oncyl_s
		&& !seek_fault_s && !write_fault_s
		|=> display_code == 8'h11;
	endproperty
	a_rwfault: assert property (p_rwfault)
		else $error("code 11 not shown");

	c_diag: cover property (@(posedge ref_clk) $rose(diag_ok_q));
	c_event: cover property (@(posedge ref_clk) diag_ok_q && event_valid);
	c_fault: cover property (@(posedge ref_clk) fault_any && diag_ok_q);
	c_wfault: cover property (@(posedge ref_clk) diag_ok_q && write_fault_s);
	c_freeze: cover property (@(posedge ref_clk) !clk_en && diag_ok_q);
endmodule
`default_nettype wire
